/* dss_regs.svh */
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH

// processor clock cycles for each phase of a DRAM access
`define DSS_ROW_CYCLES       3'h2
`define DSS_GAP_CYCLES       3'h1
`define DSS_COL_SETUP_CYCLES 3'h1
`define DSS_CAS_READ_CYCLES  3'h2
`define DSS_CAS_WRITE_CYCLES 3'h1
`define DSS_CNT_ONE          3'h1
`define DSS_CNT_ZERO         3'h0

// processor pin positions inside the synchroniser vector
`define DSS_PIN_SELECT       0
`define DSS_PIN_READ         1
`define DSS_PIN_WRITE        2

// idle and active pin levels; every DRAM side pin is active low
`define DSS_PIN_OFF          1'b1
`define DSS_PIN_ON           1'b0
`define DSS_COL_OE_OFF       2'h3
`define DSS_COL_OE_ON        2'h0
`define DSS_TA_READY         1'b0
`define DSS_SYNC_IDLE        3'h7

`endif

/* dss_pkg.sv */
package dss_pkg;

  // ==========================================================================
  // access sequencer states
  typedef enum logic [2:0] {
    DSS_IDLE       = 3'h0,
    DSS_ROW_SETUP  = 3'h1,
    DSS_ROW_STROBE = 3'h2,
    DSS_GAP        = 3'h3,
    DSS_COL_SETUP  = 3'h4,
    DSS_COL_STROBE = 3'h5,
    DSS_RELEASE    = 3'h6
  } dss_state_t;

  // ==========================================================================
  // DRAM side pins, all active low
  typedef struct packed {
    logic       row_strobe_n;
    logic       col_strobe_n;
    logic       row_latch_oe_n;
    logic [1:0] col_latch_oe_n;
  } dss_dram_t;

endpackage : dss_pkg

/* dss_sync2.sv */
`timescale 1ns/10ps
`include "dss_regs.svh"

// two flip-flop synchroniser for the processor bus strobes
module dss_sync2 (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // asynchronous pins and their synchronised copy
  input  wire logic [2:0] pin_in,
  output logic      [2:0] pin_sync
);

  logic [2:0] meta_q;

  // ==========================================================================
  // reset to the inactive (high) level of the active-low strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= `DSS_SYNC_IDLE;
      pin_sync <= `DSS_SYNC_IDLE;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end

endmodule : dss_sync2

/* dss_dram_strobe_sequencer.sv */
// Operation
// - address sits in three latches; their output enables select row or column.
// - a DRAM read or write first enables the upper row latch outputs.
// - then negate row strobe and disable row latch before the column phase.
// - column phase enables column latches, then asserts the column strobe.
// - with column strobe, drop transfer acknowledge, wait, then reassert it.
// - access ends with both strobes negated and all latch enables off.
// - access length is set by transfer acknowledge; processor must honour it.
// - row address held two cycles, column address held three cycles on reads, two on writes.
// - one cycle separates row phase from column phase.
// - column strobe asserts four cycles after the row latch enable.
// - column strobe lasts two cycles on reads, one cycle on writes.
`timescale 1ns/10ps
`include "dss_regs.svh"

module dss_dram_strobe_sequencer (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // processor external memory bus
  input  wire logic              dram_select_n,
  input  wire logic              processor_read_strobe_n,
  input  wire logic              processor_write_strobe_n,
  output logic                   transfer_acknowledge_n,
  // DRAM strobes and address latch enables
  output dss_pkg::dss_dram_t     dram_q,
  // sequencer busy flag
  output logic                   busy_q
);

  // synchronised pins, decoded requests and the sequencer registers
  logic [2:0]          pins_sync;
  logic                access_req;
  logic                read_req;
  logic                write_req;
  dss_pkg::dss_state_t state_q;
  dss_pkg::dss_state_t state_d;
  logic [2:0]          cnt_q;
  logic [2:0]          cnt_d;
  logic                is_read_q;
  logic                ta_off_d;

  // ==========================================================================
  // pins come from the processor clock tree but outside our timing, so synchronise
  // the two flops add a fixed two cycles to the column strobe lag
  dss_sync2 u_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   ({processor_write_strobe_n, processor_read_strobe_n, dram_select_n}),
    .pin_sync (pins_sync)
  );

  // ==========================================================================
  // a strobe counts only inside the DRAM select; shared by both directions
  function automatic logic strobe_hit(input logic sel_n, input logic strobe_n);
    return ~sel_n & ~strobe_n;
  endfunction : strobe_hit

  // read wins the direction when both strobes are low together
  assign read_req   = strobe_hit(pins_sync[`DSS_PIN_SELECT], pins_sync[`DSS_PIN_READ]);
  assign write_req  = strobe_hit(pins_sync[`DSS_PIN_SELECT], pins_sync[`DSS_PIN_WRITE]);
  assign access_req = read_req | write_req;

  // ==========================================================================
  // pin levels for a given state; used for both the strobe and enable outputs
  // states not listed fall through to all pins idle
  function automatic dss_pkg::dss_dram_t dram_pins(input dss_pkg::dss_state_t st);
    dss_pkg::dss_dram_t p;
    p = '{row_strobe_n: `DSS_PIN_OFF, col_strobe_n: `DSS_PIN_OFF, row_latch_oe_n: `DSS_PIN_OFF,
          col_latch_oe_n: `DSS_COL_OE_OFF};
    case (st)
      dss_pkg::DSS_ROW_SETUP:  p.row_latch_oe_n = `DSS_PIN_ON;
      dss_pkg::DSS_ROW_STROBE: begin
        p.row_latch_oe_n = `DSS_PIN_ON;
        p.row_strobe_n   = `DSS_PIN_ON;
      end
      dss_pkg::DSS_COL_SETUP:  p.col_latch_oe_n = `DSS_COL_OE_ON;
      dss_pkg::DSS_COL_STROBE: begin
        p.col_latch_oe_n = `DSS_COL_OE_ON;
        p.col_strobe_n   = `DSS_PIN_ON;
      end
      // everything else leaves the pins idle
      default:                 p = p;
    endcase
    return p;
  endfunction : dram_pins

  // ==========================================================================
  // next state and phase counter
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q + `DSS_CNT_ONE;
    case (state_q)
      dss_pkg::DSS_IDLE: begin
        // the counter restarts at one so the first row cycle is counted
        cnt_d = `DSS_CNT_ONE;
        if (access_req) begin
          state_d = dss_pkg::DSS_ROW_SETUP;
        end
      end
      dss_pkg::DSS_ROW_SETUP: begin
        state_d = dss_pkg::DSS_ROW_STROBE;
      end
      dss_pkg::DSS_ROW_STROBE: begin
        if (cnt_q >= `DSS_ROW_CYCLES) begin
          state_d = dss_pkg::DSS_GAP;
          cnt_d   = `DSS_CNT_ONE;
        end
      end
      dss_pkg::DSS_GAP: begin
        if (cnt_q >= `DSS_GAP_CYCLES) begin
          state_d = dss_pkg::DSS_COL_SETUP;
          cnt_d   = `DSS_CNT_ONE;
        end
      end
      dss_pkg::DSS_COL_SETUP: begin
        if (cnt_q >= `DSS_COL_SETUP_CYCLES) begin
          state_d = dss_pkg::DSS_COL_STROBE;
          cnt_d   = `DSS_CNT_ONE;
        end
      end
      dss_pkg::DSS_COL_STROBE: begin
        if (cnt_q >= (is_read_q ? `DSS_CAS_READ_CYCLES : `DSS_CAS_WRITE_CYCLES)) begin
          state_d = dss_pkg::DSS_RELEASE;
          cnt_d   = `DSS_CNT_ZERO;
        end
      end
      dss_pkg::DSS_RELEASE: begin
        // wait for the processor to end
        // holding here until the strobes go away stops one long strobe
        // from starting a second access
        cnt_d = `DSS_CNT_ZERO;
        if (!access_req) begin
          state_d = dss_pkg::DSS_IDLE;
        end
      end
      default: begin
        state_d = dss_pkg::DSS_IDLE;
        cnt_d   = `DSS_CNT_ZERO;
      end
    endcase
  end

  // acknowledge is held off for the whole column strobe, released with it
  // looking at state_d lets the registered pin move together with the strobe
  assign ta_off_d = (state_d == dss_pkg::DSS_COL_STROBE);

  // ==========================================================================
  // sequencer state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= dss_pkg::DSS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // phase counter; the idle branch reloads it so a stale count never shortens a phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `DSS_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // direction latched once per access: a strobe that changes mid-access
  // cannot stretch or cut the column strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      is_read_q <= 1'b0;
    end else if (state_q == dss_pkg::DSS_IDLE && access_req) begin
      is_read_q <= read_req;
    end
  end

  // ==========================================================================
  // outputs straight from flops, looked ahead by one state so pins match state_q;
  // registering them keeps decode glitches off the DRAM strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dram_q <= '{row_strobe_n: `DSS_PIN_OFF, col_strobe_n: `DSS_PIN_OFF,
                  row_latch_oe_n: `DSS_PIN_OFF, col_latch_oe_n: `DSS_COL_OE_OFF};
    end else begin
      dram_q <= dram_pins(state_d);
    end
  end

  // acknowledge sits low (ready) while idle: the processor must wait for the
  // withhold, or it ends the cycle before the column phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transfer_acknowledge_n <= `DSS_TA_READY;
    end else begin
      transfer_acknowledge_n <= ta_off_d;
    end
  end

  // busy covers the release wait too, so the host side knows when to start again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != dss_pkg::DSS_IDLE);
    end
  end

endmodule : dss_dram_strobe_sequencer

/* dss_chk.sv */
`timescale 1ns/10ps
// ============================================================
// port checker for the access sequencer
module dss_chk (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // processor bus
  input wire logic               dram_select_n,
  input wire logic               processor_read_strobe_n,
  input wire logic               processor_write_strobe_n,
  input wire logic               transfer_acknowledge_n,
  // dram side
  input wire dss_pkg::dss_dram_t dram_q,
  input wire logic               busy_q
);
  logic       ras, cas, roe;
  logic [1:0] coe;
  logic       ta;
  // short aliases keep the properties readable
  assign {ras, cas, roe, coe} = dram_q;
  assign ta = transfer_acknowledge_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_row_first; $fell(roe) |-> ras && coe == 2'h3; endproperty
  a_row_first: assert property (p_row_first) else $error("row oe not first");
  property p_row_hold; $fell(roe) |-> (!roe) [*2] ##1 roe; endproperty
  a_row_hold: assert property (p_row_hold) else $error("row oe width");
  property p_ras; $fell(roe) |=> $fell(ras) ##1 (ras && roe); endproperty
  a_ras: assert property (p_ras) else $error("ras under row oe");
  property p_gap; $rose(roe) |-> coe == 2'h3 ##1 coe == 2'h0; endproperty
  a_gap: assert property (p_gap) else $error("row to column gap");
  property p_lag; $fell(roe) |-> ##4 $fell(cas); endproperty
  a_lag: assert property (p_lag) else $error("cas lag");
  // reads hold cas and withheld acknowledge for two cycles, writes one
  property p_cas_rd;
    $fell(cas) && !processor_read_strobe_n |-> (!cas && ta && coe == 2'h0) [*2] ##1 (cas && !ta);
  endproperty
  a_cas_rd: assert property (p_cas_rd) else $error("read cas");
  property p_cas_wr;
    $fell(cas) && processor_read_strobe_n |-> (ta && coe == 2'h0) ##1 (cas && !ta);
  endproperty
  a_cas_wr: assert property (p_cas_wr) else $error("write cas");
  property p_end; $rose(cas) |-> ras && roe && coe == 2'h3; endproperty
  a_end: assert property (p_end) else $error("access end");
  property p_idle; !busy_q |-> ras && cas && roe && coe == 2'h3 && !ta; endproperty
  a_idle: assert property (p_idle) else $error("idle outputs");
  c_rd: cover property ($fell(cas) && !processor_read_strobe_n);
  c_wr: cover property ($fell(cas) && processor_read_strobe_n);
  c_both: cover property ($fell(roe) && !processor_read_strobe_n && !processor_write_strobe_n);
endmodule : dss_chk

bind dss_dram_strobe_sequencer dss_chk u_chk (.clk(clk), .rst(rst), .dram_select_n(dram_select_n),
  .processor_read_strobe_n(processor_read_strobe_n), .processor_write_strobe_n(processor_write_strobe_n),
  .transfer_acknowledge_n(transfer_acknowledge_n), .dram_q(dram_q), .busy_q(busy_q));

/* dss_host_model.sv */
`timescale 1ns/10ps
// ============================================================
// processor bus model
module dss_host_model (
  // clock
  input wire logic clk,
  // bus pins
  input wire logic ta_n,
  output logic     sel_n,
  output logic     rd_n,
  output logic     wr_n
);
  // released pins sit at their pull-up level
  initial {sel_n, rd_n, wr_n} = 3'h7;
  // one access; bounded waits so a stuck sequencer cannot hang us
  task automatic access(input logic rd, input logic wr, input int hold, output logic ok);
    int n;
    logic seen;
    @(posedge clk);
    #1 {sel_n, rd_n, wr_n} = {1'b0, !rd, !wr};
    n = 0;
    // honour acknowledge: see it withheld, then wait for its return
    while (ta_n !== 1'b1 && n < 20) begin @(posedge clk); #1; n++; end
    seen = (ta_n === 1'b1);
    while (ta_n !== 1'b0 && n < 40) begin @(posedge clk); #1; n++; end
    ok = seen && (n < 40);
    repeat (hold) @(posedge clk);
    #1 {sel_n, rd_n, wr_n} = 3'h7;
  endtask : access
  // a read strobe outside the DRAM select; the sequencer must ignore it
  task automatic stray(input int len);
    @(posedge clk);
    #1 rd_n = 1'b0;
    repeat (len) @(posedge clk);
    #1 rd_n = 1'b1;
  endtask : stray
endmodule : dss_host_model

/* dss_dram_strobe_sequencer_bench.sv */
`timescale 1ns/10ps
// ============================================================
// bench top
module dss_dram_strobe_sequencer_bench;
  // two sync flops, one edge to take the request, four cycles to cas; counted from the first low cycle
  localparam int LAG = 8;
  logic clk, rst, sel_n, rd_n, wr_n, ta_n, busy_q, ok;
  dss_pkg::dss_dram_t dram_q;
  int bad_count, compares, n_ras, n_roe, n_coe, n_cas, n_ta, cyc, lag;
  logic [31:0] seed = 32'h16A7C;
  dss_dram_strobe_sequencer dut (.clk(clk), .rst(rst), .dram_select_n(sel_n), .processor_read_strobe_n(rd_n),
    .processor_write_strobe_n(wr_n), .transfer_acknowledge_n(ta_n), .dram_q(dram_q), .busy_q(busy_q));
  dss_host_model host (.clk(clk), .ta_n(ta_n), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n));
  // 50 ns clock
  initial begin clk = 1'b0; forever #25 clk = ~clk; end
  // per-access tallies of active cycles, taken on the falling edge where outputs are settled
  always @(negedge clk) begin
    if (!dram_q.row_strobe_n) n_ras++;
    if (!dram_q.row_latch_oe_n) n_roe++;
    if (dram_q.col_latch_oe_n == 2'h0) n_coe++;
    if (!dram_q.col_strobe_n) n_cas++;
    if (ta_n) n_ta++;
    if (!sel_n) cyc++;
    if (!dram_q.col_strobe_n && lag == 0) lag = cyc;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic int exp_cas(input logic rd);
    return rd ? 2 : 1;
  endfunction : exp_cas
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // one access, then wait for idle and compare the tallies
  task automatic run(input logic rd, input logic wr, input int hold);
    int n;
    {n_ras, n_roe, n_coe} = '0;
    {n_cas, n_ta, cyc, lag} = '0;
    host.access(rd, wr, hold, ok);
    check(ok, 1'b1, "ack");
    n = 0;
    while (busy_q !== 1'b0 && n < 20) begin @(posedge clk); #1; n++; end
    check(busy_q, 1'b0, "busy");
    check(n_roe, 2, "row oe");
    check(n_ras, 1, "ras");
    check(n_cas, exp_cas(rd), "cas");
    check(n_coe, exp_cas(rd) + 1, "col oe");
    check(n_ta, exp_cas(rd), "ta");
    check(lag, LAG, "lag");
    check({ta_n, dram_q}, 6'h1F, "idle");
    $display("access rd %0b wr %0b hold %0d done", rd, wr, hold);
  endtask : run
  // watchdog: about seven times the expected run length
  initial begin #250000; bad_count++; finish_test; end
  // reset, corner cases, then random traffic
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    check({ta_n, dram_q, busy_q}, 7'h3E, "reset");
    // a read strobe outside the DRAM select must not start an access
    {n_roe, n_cas} = '0;
    host.stray(6);
    repeat (3) @(posedge clk);
    #1 check(n_roe + n_cas, 0, "stray");
    check(busy_q, 1'b0, "stray busy");
    $display("stray strobe done");
    run(1'b1, 1'b0, 0);
    run(1'b0, 1'b1, 0);
    run(1'b1, 1'b1, 3);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      run(seed[0], !seed[0] | seed[1], seed[4:2]);
    end
    // reset in the middle of an access sends every output straight to idle
    fork
      host.access(1'b1, 1'b0, 0, ok);
    join_none
    repeat (7) @(posedge clk);
    #1 rst = 1'b1;
    #1 check({ta_n, dram_q, busy_q}, 7'h3E, "reset mid access");
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    wait fork;
    check(ok, 1'b1, "ack after reset");
    repeat (8) @(posedge clk);
    #1 check(busy_q, 1'b0, "idle after reset");
    $display("reset mid access done");
    finish_test;
  end
endmodule : dss_dram_strobe_sequencer_bench
